// *** hv_port_sense_diag_regs.sv ***
`timescale 1ns/1ps
module hv_port_sense_diag_regs
  import hv_port_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  // register port
  input  wire logic [7:0]   addr_i,
  input  wire logic [7:0]   wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [7:0]   rdata_o,
  // analog sense side
  input  wire sense_in_t    sense_i,
  input  wire logic         short_ch5_i,
  input  wire logic         short_ch6_i,
  input  wire logic         drive_ch5_i,
  input  wire logic         drive_ch6_i,
  // controls and request
  output analog_ctrl_t      ctrl_o,
  output logic              driver_on_ch5_o,
  output logic              driver_on_ch6_o,
  output logic              irq_o
);

  // =====================================================================
  // storage
  logic [7:0] config_q, config_d;
  logic [7:0] test_q, test_d;
  logic [4:0] result_q, result_d;
  logic       contact_q, contact_d;
  logic       short5_q, short5_d;
  logic       short6_q, short6_d;
  logic [7:0] rdata_q, rdata_d;

  // =====================================================================
  // address decode
  wire sel_cfg  = (addr_i == ADDR_SENSE_DRIVER_CONFIG);
  wire sel_sts  = (addr_i == ADDR_SENSE_DRIVER_STATUS);
  wire sel_tst  = (addr_i == ADDR_POWER_TRIM_TEST);
  wire wr_cfg   = wr_i & sel_cfg;
  wire wr_sts   = wr_i & sel_sts;
  wire wr_tst   = wr_i & sel_tst;

  // =====================================================================
  // sense result selection per pin
  wire [4:0] sense_en  = config_q[SENSE_PINS-1:0];
  // input direction takes the high-voltage input block instead
  wire [4:0] raw_sense = (sense_i.dir_out & sense_i.contact) |
                         (~sense_i.dir_out & sense_i.hv_in_low);
  // disabled pins hold their last result, so enabling flags an edge only if the input now differs from it
  assign result_d = (sense_en & raw_sense) | (~sense_en & result_q);
  wire [4:0] result_edge = (result_d ^ result_q) & sense_en;

  // =====================================================================
  // sticky flags: a set in the same cycle as the clearing write wins
  assign contact_d = (|result_edge) |
                     (contact_q & ~(wr_sts & wdata_i[STS_CONTACT_FLAG]));
  assign short5_d  = short_ch5_i |
                     (short5_q & ~(wr_sts & wdata_i[STS_SHORT_FLAG5]));
  assign short6_d  = short_ch6_i |
                     (short6_q & ~(wr_sts & wdata_i[STS_SHORT_FLAG6]));

  // =====================================================================
  // writable registers
  assign config_d = wr_cfg ? wdata_i : config_q;
  assign test_d   = wr_tst ? (wdata_i & TEST_WRITE_MASK) : test_q;

  // =====================================================================
  // read mux, answer one cycle after the strobe
  wire [7:0] status_rd = {contact_q, short6_q, short5_q, result_q};
  assign rdata_d = !rd_i  ? 8'h00 :
                   sel_cfg ? config_q :
                   sel_sts ? status_rd :
                   sel_tst ? test_q : 8'h00;

  // =====================================================================
  // state update
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      config_q  <= CONFIG_RESET;
      test_q    <= TEST_RESET;
      result_q  <= STATUS_RESET[4:0];
      contact_q <= 1'b0;
      short5_q  <= 1'b0;
      short6_q  <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      config_q  <= config_d;
      test_q    <= test_d;
      result_q  <= result_d;
      contact_q <= contact_d;
      short5_q  <= short5_d;
      short6_q  <= short6_d;
      rdata_q   <= rdata_d;
    end
  end

  // =====================================================================
  // outputs
  assign rdata_o = rdata_q;
  assign ctrl_o.sense_en           = sense_en;
  assign ctrl_o.hv_inputs_off      = test_q[TST_HV_INPUTS_OFF];
  assign ctrl_o.supply_scaler_off  = test_q[TST_SCALER_OFF];
  assign ctrl_o.low_side_block_off = test_q[TST_LOW_SIDE_OFF];
  assign ctrl_o.reg_trim           = test_q[TRIM_BITS-1:0];
  // driver stays off while flagged or while the low-side block is off
  assign driver_on_ch5_o = drive_ch5_i & ~short5_q & ~test_q[TST_LOW_SIDE_OFF];
  assign driver_on_ch6_o = drive_ch6_i & ~short6_q & ~test_q[TST_LOW_SIDE_OFF];
  // combined request, each source gated by its own enable
  assign irq_o = (contact_q & config_q[CFG_CONTACT_IRQ_EN]) |
                 (short6_q & config_q[CFG_SHORT_IRQ_EN6]) |
                 (short5_q & config_q[CFG_SHORT_IRQ_EN5]);

endmodule // hv_port_sense_diag_regs

// *** hv_port_pkg.sv ***
package hv_port_pkg;

  // =====================================================================
  // register map
  localparam logic [7:0] ADDR_SENSE_DRIVER_CONFIG = 8'h26;
  localparam logic [7:0] ADDR_SENSE_DRIVER_STATUS = 8'h27;
  localparam logic [7:0] ADDR_POWER_TRIM_TEST     = 8'h2F;

  // =====================================================================
  // reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] TEST_RESET   = 8'h00;

  // =====================================================================
  // field positions
  localparam int CFG_CONTACT_IRQ_EN = 7;
  localparam int CFG_SHORT_IRQ_EN6  = 6;
  localparam int CFG_SHORT_IRQ_EN5  = 5;
  localparam int STS_CONTACT_FLAG   = 7;
  localparam int STS_SHORT_FLAG6    = 6;
  localparam int STS_SHORT_FLAG5    = 5;
  localparam int TST_HV_INPUTS_OFF  = 7;
  localparam int TST_SCALER_OFF     = 4;
  localparam int TST_LOW_SIDE_OFF   = 3;
  localparam int SENSE_PINS         = 5;
  localparam int TRIM_BITS          = 3;

  // only bits 7 and 4..0 of the test register are stored
  localparam logic [7:0] TEST_WRITE_MASK = 8'h9F;

  // =====================================================================
  // per-pin analog sense inputs
  typedef struct packed {
    logic [4:0] contact;    // contact sense block result
    logic [4:0] hv_in_low;  // high-voltage input below low threshold
    logic [4:0] dir_out;    // pin direction, 1 = output
  } sense_in_t;

  // analog control outputs
  typedef struct packed {
    logic [4:0] sense_en;
    logic       hv_inputs_off;
    logic       supply_scaler_off;
    logic       low_side_block_off;
    logic [2:0] reg_trim;
  } analog_ctrl_t;

endpackage : hv_port_pkg

// *** hv_port_assertions.sv ***
`timescale 1ns/1ps
// =====================================================================
// port checker
module hv_port_assertions
  import hv_port_pkg::*;
(
  // clock, reset and register port
  input wire logic       core_clk_i, rstn_i, wr_i, rd_i,
  input wire logic [7:0] addr_i, wdata_i, rdata_o,
  // analog side
  input wire sense_in_t  sense_i,
  input wire logic       short_ch5_i, short_ch6_i, drive_ch5_i, drive_ch6_i,
  input wire analog_ctrl_t ctrl_o,
  input wire logic       driver_on_ch5_o, driver_on_ch6_o, irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence rd_sts; rd_i && addr_i == ADDR_SENSE_DRIVER_STATUS; endsequence
  sequence wr_tst; wr_i && addr_i == ADDR_POWER_TRIM_TEST; endsequence
  sequence wr_cfg; wr_i && addr_i == ADDR_SENSE_DRIVER_CONFIG; endsequence
  drv_gate5_a: assert property (driver_on_ch5_o |-> drive_ch5_i && !ctrl_o.low_side_block_off)
    else $error("ch5 driver on while gated");
  drv_gate6_a: assert property (driver_on_ch6_o |-> drive_ch6_i && !ctrl_o.low_side_block_off)
    else $error("ch6 driver on while gated");
  short_off_a: assert property (short_ch5_i |=> !driver_on_ch5_o)
    else $error("ch5 driver stays on after short");
  short_seen_a: assert property (short_ch6_i ##1 rd_sts |=> rdata_o[STS_SHORT_FLAG6])
    else $error("ch6 short flag missing");
  test_gap_a: assert property (rd_i && addr_i == ADDR_POWER_TRIM_TEST |=> rdata_o[6:5] == 2'b00)
    else $error("test bits 6..5 not zero");
  trim_kept_a: assert property (wr_tst |=> ctrl_o.reg_trim == $past(wdata_i[2:0]))
    else $error("trim field not stored");
  power_offs_a: assert property (wr_tst |=> {ctrl_o.hv_inputs_off, ctrl_o.supply_scaler_off,
    ctrl_o.low_side_block_off} == {$past(wdata_i[7]), $past(wdata_i[4]), $past(wdata_i[3])})
    else $error("power-off controls wrong");
  sense_en_a: assert property (wr_cfg |=> ctrl_o.sense_en == $past(wdata_i[4:0]))
    else $error("sense enables wrong");
  short_irq_a: assert property ((wr_cfg ##0 wdata_i[5]) ##1 (!wr_i && short_ch5_i) |=> irq_o)
    else $error("no request on ch5 short");
endmodule // hv_port_assertions
bind hv_port_sense_diag_regs hv_port_assertions i_hv_port_assertions (.*);

// *** hv_pin_loads.sv ***
`timescale 1ns/1ps
// =====================================================================
// switches and loads on the high-voltage pins
module hv_pin_loads
  import hv_port_pkg::*;
(
  input  wire logic [4:0] contact_i, hv_i, dir_i,
  input  wire logic       fault5_i, fault6_i, drv5_i, drv6_i,
  output sense_in_t       sense_o,
  output logic            short5_o, short6_o
);
  // an input pin gives no valid contact reading: show the inverse of its hv level
  assign sense_o = '{(contact_i & dir_i) | (~hv_i & ~dir_i), hv_i, dir_i};
  // a shorted load only draws excess current while its driver conducts
  assign short5_o = fault5_i & drv5_i;
  assign short6_o = fault6_i & drv6_i;
endmodule // hv_pin_loads

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(a,b) begin samples_checked++; if ((a)!==(b)) begin err_count++; \
  $display("unexpected at %0t: %h %h", $time, a, b); end end
// =====================================================================
// bench top
module testbench;
  import hv_port_pkg::*;
  logic core_clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, pend = 0;
  logic drv5 = 0, drv6 = 0, f5 = 0, f6 = 0, sh5, sh6, on5, on6, irq;
  logic [7:0] addr_i = 0, wdata_i = 0, d, rdata;
  logic [4:0] con = 0, hv = 0, dir = 0, res = 0, v;
  logic [8:0] q[$], e;
  int err_count = 0, samples_checked = 0, i;
  sense_in_t sense;
  analog_ctrl_t ctrl;
  initial forever #5 core_clk_i = ~core_clk_i;
  hv_port_sense_diag_regs i_hv_port_sense_diag_regs (.core_clk_i, .rstn_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o(rdata), .sense_i(sense), .short_ch5_i(sh5), .short_ch6_i(sh6),
    .drive_ch5_i(drv5), .drive_ch6_i(drv6), .ctrl_o(ctrl), .driver_on_ch5_o(on5),
    .driver_on_ch6_o(on6), .irq_o(irq));
  hv_pin_loads i_hv_pin_loads (.contact_i(con), .hv_i(hv), .dir_i(dir), .fault5_i(f5),
    .fault6_i(f6), .drv5_i(on5), .drv6_i(on6), .sense_o(sense), .short5_o(sh5), .short6_o(sh6));
  task automatic wr_t(input logic [7:0] a, input logic [7:0] w);
    @(posedge core_clk_i); addr_i <= a; wdata_i <= w; wr_i <= 1'b1;
    @(posedge core_clk_i); wr_i <= 1'b0;
  endtask
  // the expected {request, read data} is noted as the read is issued
  task automatic rd_t(input logic [7:0] a, input logic [8:0] x);
    @(posedge core_clk_i); addr_i <= a; rd_i <= 1'b1; q.push_back(x);
    @(posedge core_clk_i); rd_i <= 1'b0;
  endtask
  task summarize;
    $display("errors %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe: sample mid-cycle
  always @(posedge core_clk_i) pend <= rd_i;
  always @(negedge core_clk_i) if (pend) begin
    e = q.pop_front();
    `CHK({irq, rdata}, e)
  end
  initial begin
    repeat (3000) @(posedge core_clk_i);
    err_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'h6B8F0EE0));
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1; drv5 <= 1'b1; drv6 <= 1'b1;
    wr_t(8'h30, 8'hFF);
    rd_t(8'h26, 9'h000); rd_t(8'h27, 9'h000); rd_t(8'h2F, 9'h000); rd_t(8'h30, 9'h000);
    // inputs stay quiet here so enabling pins raises no change
    repeat (4) begin
      d = $urandom; wr_t(8'h2F, d); rd_t(8'h2F, {1'b0, d & TEST_WRITE_MASK});
      d = $urandom; wr_t(8'h26, d); rd_t(8'h26, {1'b0, d});
    end
    wr_t(8'h2F, 8'h00);
    // shorts with requests enabled, then masked
    for (i = 0; i < 2; i++) begin
      wr_t(8'h26, i ? 8'h00 : 8'h60); f5 <= 1'b1;
      rd_t(8'h27, {~i[0], 8'h20}); f5 <= 1'b0; f6 <= 1'b1;
      rd_t(8'h27, {~i[0], 8'h60}); f6 <= 1'b0;
      wr_t(8'h27, 8'h60); rd_t(8'h27, 9'h000);
    end
    // a change on an output pin, then on an input pin
    wr_t(8'h26, 8'h9F);
    for (i = 0; i < 2; i++) begin
      v = res ^ 5'(($urandom % 31) + 1); dir <= i ? 5'h00 : 5'h1F;
      if (i == 0) con <= v; else hv <= v;
      res = v;
      rd_t(8'h27, {1'b1, 3'b100, res}); wr_t(8'h27, 8'h00);
      rd_t(8'h27, {1'b1, 3'b100, res}); wr_t(8'h27, 8'h80);
      rd_t(8'h27, {1'b0, 3'b000, res});
    end
    summarize();
  end
endmodule // testbench
